// ### serial_rx_defines.svh
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH

// Register offsets (byte addresses on the register port)
`define SRX_HOLDING_OFFSET   13'h1fb8
`define SRX_FLAGS_OFFSET     13'h1fbc
`define SRX_IRQ_STAT_OFFSET  13'h1fbe
`define SRX_IRQ_MASK_OFFSET  13'h1fc0
`define SRX_CTRL_OFFSET      13'h1fc2

// Reset values
`define SRX_HOLDING_RESET    8'h00
`define SRX_MASK_RESET       8'h00
`define SRX_CTRL_RESET       8'h00

// Field positions in the serial port flag register
`define SRX_FLAG_OVERFLOW    2
`define SRX_FLAG_RX_FULL     6

// Interrupt status / mask bit positions
`define SRX_IRQ_RX_DONE      0
`define SRX_IRQ_OVERFLOW     1

// Control register bit positions
`define SRX_CTRL_ENABLE      0

// Line timing: bit time in core clocks (derived from 125 MHz)
`define SRX_CLK_MHZ          125
`define SRX_BAUD_KBPS        1000
`define SRX_BIT_CYCLES       ((`SRX_CLK_MHZ * 1000) / `SRX_BAUD_KBPS)
`define SRX_HALF_CYCLES      (`SRX_BIT_CYCLES / 2)
`define SRX_DATA_BITS        8

`endif

// ### serial_rx_holding_buffer.sv
// Operation
// - Transfer byte only after final data bit
// - Shift next byte while holding byte waits
// - Load before read sets overflow flag bit 2
// - Holding register loads as whole byte
// - Holding register eight bits, resets to 00H
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "serial_rx_defines.svh"

module serial_rx_holding_buffer (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [12:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Serial line
   input  wire logic        i_rx_line,
   // Interrupt
   output logic             o_irq
);

   localparam int BIT_CYC  = `SRX_BIT_CYCLES;
   localparam int HALF_CYC = `SRX_HALF_CYCLES;

   serial_rx_pkg::reg_req_s req;              // Bundled bus request
   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   logic       line_meta_q;                   // First sync stage only
   logic       line_q;                        // Usable line level
   serial_rx_pkg::rx_state_e state_q;         // Receiver sequencer
   logic [15:0] cnt_q;                        // Bit time counter
   logic [2:0]  bit_q;                        // Data bit index
   logic [7:0]  shift_q;                      // Receive shift register
   logic [7:0]  hold_q;                       // Holding register
   logic        full_q;                       // Holding byte unread
   logic        ovf_q;                        // Sticky overflow flag
   logic [1:0]  stat_q;                       // Interrupt status
   logic [1:0]  mask_q;                       // Interrupt mask
   logic        en_q;                         // Receiver enable
   logic        load;                         // Byte completes now
   logic        hold_rd;                      // Software reads holding
   logic        flags_wr;                     // Flag register write

   assign hold_rd  = req.rd && req.addr == `SRX_HOLDING_OFFSET;
   assign flags_wr = req.wr && req.addr == `SRX_FLAGS_OFFSET;
   // Transfer happens as the last data bit is sampled
   assign load = state_q == serial_rx_pkg::ST_DATA &&
                 cnt_q == 16'(BIT_CYC - 1) && bit_q == 3'd7;

   // Two-flop synchroniser; the first stage feeds nothing else
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         line_meta_q <= 1'b1;
         line_q      <= 1'b1;
      end else begin
         line_meta_q <= i_rx_line;
         line_q      <= line_meta_q;
      end
   end

   // Receive sequencer: runs regardless of holding state
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= serial_rx_pkg::ST_IDLE;
         cnt_q   <= 16'h0000;
         bit_q   <= 3'h0;
      end else begin
         unique case (state_q)
            serial_rx_pkg::ST_IDLE: begin
               cnt_q <= 16'h0000;
               bit_q <= 3'h0;
               // Low line level starts a frame when enabled
               if (en_q && !line_q) begin
                  state_q <= serial_rx_pkg::ST_START;
               end
            end
            serial_rx_pkg::ST_START: begin
               if (cnt_q == 16'(HALF_CYC - 1)) begin
                  cnt_q <= 16'h0000;
                  // A glitch shorter than half a bit is dropped
                  state_q <= line_q ? serial_rx_pkg::ST_IDLE
                                    : serial_rx_pkg::ST_DATA;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            serial_rx_pkg::ST_DATA: begin
               if (cnt_q == 16'(BIT_CYC - 1)) begin
                  cnt_q <= 16'h0000;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'd7) begin
                     state_q <= serial_rx_pkg::ST_STOP;
                  end
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            serial_rx_pkg::ST_STOP: begin
               // Wait one bit time, to mid stop bit, then rearm
               if (cnt_q == 16'(BIT_CYC - 1)) begin
                  cnt_q   <= 16'h0000;
                  state_q <= serial_rx_pkg::ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
         endcase
      end
   end

   // Shift register collects LSB first at mid bit
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_q <= 8'h00;
      end else if (state_q == serial_rx_pkg::ST_DATA &&
                   cnt_q == 16'(BIT_CYC - 1)) begin
         shift_q <= {line_q, shift_q[7:1]};
      end
   end

   // Holding register takes the full byte in one edge
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_q <= `SRX_HOLDING_RESET;
      end else if (load) begin
         hold_q <= {line_q, shift_q[7:1]};
      end
   end

   // Unread tracking; a load in the same cycle as a read wins
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         full_q <= 1'b0;
      end else if (load) begin
         full_q <= 1'b1;
      end else if (hold_rd) begin
         full_q <= 1'b0;
      end
   end

   // Overflow flag: sticky, write one to clear, set wins
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ovf_q <= 1'b0;
      end else if (load && full_q && !hold_rd) begin
         ovf_q <= 1'b1;
      end else if (flags_wr && req.wdata[`SRX_FLAG_OVERFLOW]) begin
         ovf_q <= 1'b0;
      end
   end

   // Control and mask registers
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         en_q   <= 1'b0;
         mask_q <= 2'h0;
      end else if (req.wr) begin
         if (req.addr == `SRX_CTRL_OFFSET) begin
            en_q <= req.wdata[`SRX_CTRL_ENABLE];
         end
         if (req.addr == `SRX_IRQ_MASK_OFFSET) begin
            mask_q <= req.wdata[1:0];
         end
      end
   end

   // Interrupt status, per bit: set wins over write-one clear
   for (genvar g = 0; g < 2; g++) begin : g_stat
      logic ev;                                 // Event for this bit
      assign ev = (g == `SRX_IRQ_RX_DONE) ? load
                                          : (load && full_q && !hold_rd);
      always_ff @(posedge i_core_clk or posedge i_rst) begin
         if (i_rst) begin
            stat_q[g] <= 1'b0;
         end else if (ev) begin
            stat_q[g] <= 1'b1;
         end else if (req.wr && req.addr == `SRX_IRQ_STAT_OFFSET &&
                      req.wdata[g]) begin
            stat_q[g] <= 1'b0;
         end
      end
   end

   // Interrupt output registered
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(stat_q & mask_q);
      end
   end

   // Read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            `SRX_HOLDING_OFFSET:  o_rdata <= hold_q;
            `SRX_FLAGS_OFFSET:    o_rdata <= 8'(ovf_q) <<
                                            `SRX_FLAG_OVERFLOW |
                                            8'(full_q) <<
                                            `SRX_FLAG_RX_FULL;
            `SRX_IRQ_STAT_OFFSET: o_rdata <= {6'h00, stat_q};
            `SRX_IRQ_MASK_OFFSET: o_rdata <= {6'h00, mask_q};
            `SRX_CTRL_OFFSET:     o_rdata <= {7'h00, en_q};
            default:              o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // Assertions
   // Judged from the holding register itself, not from the load term
   AST_LOAD_AFTER_LAST_BIT: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !$stable(hold_q) |-> $past(state_q) == serial_rx_pkg::ST_DATA &&
                           $past(bit_q) == 3'd7 &&
                           $past(cnt_q) == 16'(BIT_CYC - 1))
      else $error("holding loaded before final bit");
   AST_HOLD_WHOLE_BYTE: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      load |=> hold_q == {$past(line_q), $past(shift_q[7:1])})
      else $error("holding not loaded as whole byte");
   AST_HOLD_STABLE: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !load |=> $stable(hold_q))
      else $error("holding changed without load");
   AST_OVF_SET: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      load && full_q && !hold_rd |=> ovf_q ##1 ovf_q || $past(flags_wr))
      else $error("overflow not set");
   AST_NO_FALSE_OVF: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !ovf_q && !(load && full_q) |=> !ovf_q)
      else $error("overflow set without cause");
   AST_READ_CONSUMES: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      hold_rd && !load |=> !full_q)
      else $error("read did not consume byte");
   AST_READ_DATA: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      hold_rd |=> o_rdata == $past(hold_q))
      else $error("holding read data wrong");
   AST_IRQ_LEVEL: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      |(stat_q & mask_q) |=> o_irq)
      else $error("interrupt not raised");

   COV_BYTE: cover property (@(posedge i_core_clk) disable iff (i_rst)
      load);
   COV_OVF: cover property (@(posedge i_core_clk) disable iff (i_rst)
      load && full_q);
   COV_READ_THEN_LOAD: cover property (@(posedge i_core_clk)
      disable iff (i_rst) hold_rd ##[1:300] load);

endmodule : serial_rx_holding_buffer

// ### serial_rx_holding_buffer_test.sv
`timescale 1ns/100ps
`include "serial_rx_defines.svh"
module serial_rx_holding_buffer_test;
   logic        i_core_clk = 1'b0;      // 125 MHz core clock
   logic        i_rst = 1'b1;           // Held high at start
   logic [12:0] i_addr = '0;            // Register address
   logic [7:0]  i_wdata = '0;           // Register write data
   logic        i_wr = 1'b0;            // Write strobe
   logic        i_rd = 1'b0;            // Read strobe
   logic [7:0]  o_rdata;                // Read data
   logic        line;                   // Serial line
   logic        o_irq;                  // Interrupt
   logic        send = 1'b0;            // Frame request
   logic [7:0]  tx_byte = '0;           // Byte to send
   logic        busy;                   // Frame in flight
   int          bad_count = 0;          // Mismatches
   int          samples_checked = 0;    // Comparisons
   // Sent byte above, expected holding value below
   logic [15:0] rows [6] = '{16'h5a5a, 16'ha5a5, 16'h0101,
                             16'h8080, 16'hffff, 16'h0000};

   serial_rx_holding_buffer serial_rx_holding_buffer_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_rx_line(line), .o_irq(o_irq));
   serial_rx_line_driver #(.BIT_CYCLES(125)) serial_rx_line_driver_i (
      .i_core_clk(i_core_clk), .i_send(send), .i_byte(tx_byte),
      .o_line(line), .o_busy(busy));

   // Clock generator
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end

   task automatic close_out;
      $display("checked %0d, failed %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [7:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One-cycle write
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask : wr

   // One-cycle read; data is looked at in the following cycle only
   task automatic rd(input string nm, input logic [12:0] a,
                     input logic [7:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 chk(nm, exp, o_rdata);
   endtask : rd

   // Send a frame; optionally read holding just before the last bit lands
   task automatic frame(input logic [7:0] b, input bit peek,
                        input logic [7:0] prev);
      @(posedge i_core_clk);
      send    <= 1'b1;
      tx_byte <= b;
      @(posedge i_core_clk);
      send <= 1'b0;
      // Bit 6 is in by now, bit 7 is still some cycles away
      repeat (1050) @(posedge i_core_clk);
      if (peek) rd("mid", `SRX_HOLDING_OFFSET, prev);
      for (int n = 0; n < 3000 && busy; n++) @(posedge i_core_clk);
      if (busy) begin
         bad_count++;
         close_out();
      end
   endtask : frame

   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd("reset", `SRX_HOLDING_OFFSET, 8'h00);
      rd("flags", `SRX_FLAGS_OFFSET, 8'h00);
      wr(`SRX_CTRL_OFFSET, 8'h01);
      wr(`SRX_IRQ_MASK_OFFSET, 8'h03);
      // Ordinary bytes; each read consumes the byte before the next load
      for (int r = 0; r < 6; r++) begin
         frame(rows[r][15:8], 1'b1, r ? rows[r-1][7:0] : 8'h00);
         chk("irq", 8'h01, {7'h00, o_irq});
         rd("hold", `SRX_HOLDING_OFFSET, rows[r][7:0]);
         rd("flags", `SRX_FLAGS_OFFSET, 8'h00);
         wr(`SRX_IRQ_STAT_OFFSET, 8'h03);
         repeat (2) @(posedge i_core_clk);
         chk("irq clr", 8'h00, {7'h00, o_irq});
      end
      // Two loads with no read between: overflow, newest byte whole
      frame(8'h3c, 1'b0, 8'h00);
      frame(8'hc3, 1'b0, 8'h00);
      rd("ovf", `SRX_FLAGS_OFFSET, 8'h44);
      rd("stat", `SRX_IRQ_STAT_OFFSET, 8'h03);
      rd("last", `SRX_HOLDING_OFFSET, 8'hc3);
      rd("sticky", `SRX_FLAGS_OFFSET, 8'h04);
      wr(`SRX_FLAGS_OFFSET, 8'h04);
      rd("ovf clr", `SRX_FLAGS_OFFSET, 8'h00);
      // Masked event leaves the interrupt low until unmasked
      wr(`SRX_IRQ_STAT_OFFSET, 8'h03);
      wr(`SRX_IRQ_MASK_OFFSET, 8'h00);
      frame(8'h96, 1'b0, 8'h00);
      chk("masked", 8'h00, {7'h00, o_irq});
      wr(`SRX_IRQ_MASK_OFFSET, 8'h01);
      repeat (2) @(posedge i_core_clk);
      chk("unmask", 8'h01, {7'h00, o_irq});
      // Holding is read-only; unmapped place reads zero
      wr(`SRX_HOLDING_OFFSET, 8'h77);
      rd("ro", `SRX_HOLDING_OFFSET, 8'h96);
      rd("unmapped", 13'h1fb0, 8'h00);
      // Read data stands one cycle only, then drops to zero
      @(posedge i_core_clk);
      #1 chk("rdata idle", 8'h00, o_rdata);
      // Mid-run reset clears the nonzero holding byte and the enable
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      chk("irq rst", 8'h00, {7'h00, o_irq});
      rd("hold rst", `SRX_HOLDING_OFFSET, 8'h00);
      rd("ctrl rst", `SRX_CTRL_OFFSET, 8'h00);
      rd("flags rst", `SRX_FLAGS_OFFSET, 8'h00);
      close_out();
   end
endmodule : serial_rx_holding_buffer_test

// ### serial_rx_line_driver.sv
`timescale 1ns/100ps
// Remote transmitter: start bit, 8 data bits LSB first, stop bit
module serial_rx_line_driver #(
   parameter int BIT_CYCLES = 125       // Core clocks per bit
) (
   // Clock
   input  wire logic       i_core_clk,
   // Request from the bench
   input  wire logic       i_send,
   input  wire logic [7:0] i_byte,
   // Line toward the receiver
   output logic            o_line,
   output logic            o_busy
);
   logic [7:0] byte_q;                  // Frame being sent
   int         cnt_q;                   // Clocks into the frame
   int         idx;                     // Bit slot of the frame

   initial begin
      o_busy = 1'b0;
      cnt_q  = 0;
   end

   // Start a frame on request; the stop slot outlasts the receiver's wait
   always @(posedge i_core_clk) begin
      if (!o_busy && i_send) begin
         byte_q <= i_byte;
         cnt_q  <= 0;
         o_busy <= 1'b1;
      end else if (o_busy) begin
         cnt_q  <= cnt_q + 1;
         o_busy <= (cnt_q != 10 * BIT_CYCLES - 1);
      end
   end

   // Idle line rests high; slot 0 is start, slot 9 is stop
   always_comb begin
      idx = cnt_q / BIT_CYCLES;
      if (!o_busy || idx >= 9) begin
         o_line = 1'b1;
      end else if (idx == 0) begin
         o_line = 1'b0;
      end else begin
         o_line = byte_q[idx - 1];
      end
   end
endmodule : serial_rx_line_driver

// ### serial_rx_pkg.sv
package serial_rx_pkg;

   // Receiver sequencing states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA  = 4'b0100,
      ST_STOP  = 4'b1000
   } rx_state_e;

   // Register port request
   typedef struct packed {
      logic [12:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

endpackage : serial_rx_pkg
